// ---- verilog/spcd_cfg.svh ----
// Constants of the serial parameter command detector: offsets, fields, resets, timing
`ifndef SPCD_CFG_SVH
`define SPCD_CFG_SVH

// Clock and derived timing
`define SPCD_CLK_NS 50
`define SPCD_CLK_HZ (1000000000 / `SPCD_CLK_NS)
`define SPCD_MIN_IDLE_NS 100000
`define SPCD_MIN_IDLE_CYCLES ((`SPCD_MIN_IDLE_NS + `SPCD_CLK_NS - 1) / `SPCD_CLK_NS)
`define SPCD_BEAT_TICK_NS 1000000
`define SPCD_BEAT_TICK_CYCLES (`SPCD_BEAT_TICK_NS / `SPCD_CLK_NS)

// Register byte addresses
`define SPCD_ADDR_CTRL 8'h00
`define SPCD_ADDR_LINE 8'h04
`define SPCD_ADDR_PACK 8'h08
`define SPCD_ADDR_BEAT 8'h0C
`define SPCD_ADDR_MEM 8'h10
`define SPCD_ADDR_MAC_LO 8'h14
`define SPCD_ADDR_MAC_HI 8'h18
`define SPCD_ADDR_STAT 8'h1C

// Control register fields
`define SPCD_CTRL_DET 0
`define SPCD_CTRL_MODE 1
`define SPCD_CTRL_BEAT_SER 3
`define SPCD_CTRL_BEAT_EN 4
`define SPCD_CTRL_REG_EN 5
`define SPCD_CTRL_REG_EACH 6
`define SPCD_CTRL_REG_MAC 7
`define SPCD_CTRL_RST 8'h01

// Line format byte fields
`define SPCD_FMT_LEN 0
`define SPCD_FMT_STOP 2
`define SPCD_FMT_PEN 3
`define SPCD_FMT_PTYPE 4
`define SPCD_FMT_RSVD 6

// Line and framing reset values
`define SPCD_BAUD_RST 24'h01C200
`define SPCD_FMT_RST 8'h03
`define SPCD_PACK_LEN_RST 10'h190
`define SPCD_IDLE_CHARS_RST 4'h4
`define SPCD_CHAR_BITS 8'h0A

// Command frame
`define SPCD_HDR0 8'h55
`define SPCD_HDR1 8'hAA
`define SPCD_HDR2 8'h55
`define SPCD_CMD_LAST 3'h7
`define SPCD_MIN_BAUD 24'h000258
`define SPCD_CONTENT_MAX 6'h28
`define SPCD_MAC_LEN 6'h06

// Memory write port fields
`define SPCD_MEM_IDX 8
`define SPCD_MEM_SEL 16

`endif

// ---- verilog/spcd_pkg.sv ----
// Types shared by the serial parameter command detector
package spcd_pkg;

	typedef enum logic [1:0] {
		MODE_STREAM_CLIENT,
		MODE_STREAM_SERVER,
		MODE_DGRAM_CLIENT,
		MODE_DGRAM_SERVER
	} spcd_mode_type;

	typedef enum logic [1:0] {
		P_IDLE,
		P_DRAIN,
		P_BEAT
	} spcd_ser_state_type;

	typedef enum logic [1:0] {
		N_IDLE,
		N_REG,
		N_BEAT
	} spcd_net_state_type;

	typedef struct packed {
		logic [7:0] fmt;
		logic [23:0] baud;
	} spcd_line_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} spcd_byte_type;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
		logic last;
		logic nodata;
	} spcd_net_type;

endpackage

// ---- verilog/spcd_uart_tx.sv ----
// Serial transmitter with on-the-fly line settings, switched only between characters
`timescale 1ns/100ps
`include "spcd_cfg.svh"
module spcd_uart_tx (
	input wire logic pclk,
	input wire logic presetn,
	input spcd_pkg::spcd_line_type line,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	output logic in_ready,
	output logic txd,
	output logic bit_tick
);
	import spcd_pkg::*;

	spcd_line_type cur;
	logic [24:0] acc;
	logic [25:0] sum;
	logic [11:0] frame;
	logic [11:0] next_frame;
	logic [3:0] left;
	logic [3:0] next_left;
	logic [3:0] nbits;
	logic pen;
	logic x;
	logic par;

	// Fractional rate generator avoids a divider
	always_comb begin
		sum = {1'b0, acc} + {2'h0, cur.baud};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= 25'h0;
			bit_tick <= 1'b0;
		end else if (sum >= 26'(`SPCD_CLK_HZ)) begin
			acc <= 25'(sum - 26'(`SPCD_CLK_HZ));
			bit_tick <= 1'b1;
		end else begin
			acc <= sum[24:0];
			bit_tick <= 1'b0;
		end
	end

	always_comb begin
		nbits = 4'h5 + {2'h0, line.fmt[`SPCD_FMT_LEN +: 2]};
		pen = line.fmt[`SPCD_FMT_PEN];
		x = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nbits)) begin
				x = x ^ in_data[i];
			end
		end
		unique case (line.fmt[`SPCD_FMT_PTYPE +: 2])
			2'h0: par = ~x;
			2'h1: par = x;
			2'h2: par = 1'b1;
			2'h3: par = 1'b0;
		endcase
		next_frame = 12'hFFF;
		next_frame[0] = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (i < int'(nbits)) begin
				next_frame[i + 1] = in_data[i];
			end
		end
		if (pen) begin
			next_frame[nbits + 4'h1] = par;
		end
		// Start, data, parity, stop bits plus one closing tick
		next_left = 4'h3 + nbits + {3'h0, pen} + {3'h0, line.fmt[`SPCD_FMT_STOP]};
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur <= {`SPCD_FMT_RST, `SPCD_BAUD_RST};
			frame <= 12'hFFF;
			left <= 4'h0;
			txd <= 1'b1;
			in_ready <= 1'b1;
		end else if (left == 4'h0) begin
			txd <= 1'b1;
			cur <= line;
			if (in_valid && in_ready) begin
				frame <= next_frame;
				left <= next_left;
				in_ready <= 1'b0;
			end else begin
				in_ready <= 1'b1;
			end
		end else if (bit_tick) begin
			txd <= frame[0];
			frame <= {1'b1, frame[11:1]};
			left <= left - 4'h1;
		end
	end

endmodule

// ---- verilog/spcd_top.sv ----
// Serial parameter command detector with serial framing, heartbeat and registration
//
// Summary of operation
// - Close network frame at 400 serial bytes
// - Command is exactly eight bytes long
// - Header is the fixed sequence 55 AA 55
// - Baud is 24 bits, MSB first, min 600
// - Checksum is low byte of four-byte sum
// - Decode format byte: length, stop, parity
// - Valid command applies settings, is swallowed
// - Invalid candidate forwarded unchanged as payload
// - Settings apply at once, never stored
// - Detection works in every network mode
// - Detection on after reset, switchable off
// - Heartbeat goes to network or serial, not both
// - Network heartbeat only in client modes
// - Heartbeat content up to 40 bytes
// - Registration once on connect or per packet
// - Registration is MAC or custom 40 bytes
// - Close packet on idle gap, minimum 0.1 ms
`timescale 1ns/100ps
`include "spcd_cfg.svh"
module spcd_top #(
	parameter int TICK_CYCLES = `SPCD_BEAT_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input spcd_pkg::spcd_byte_type net_rx,
	output logic net_rx_ready,
	input spcd_pkg::spcd_byte_type ser_rx,
	output spcd_pkg::spcd_net_type net_tx,
	input wire logic net_tx_ready,
	input wire logic link_up,
	output logic uart_txd
);
	import spcd_pkg::*;

	logic [7:0] ctrl;
	spcd_line_type line;
	spcd_line_type new_line;
	logic cmd_apply;
	logic [9:0] pack_len;
	logic [3:0] idle_chars;
	logic [5:0] beat_len;
	logic [5:0] reg_len;
	logic [15:0] beat_period;
	logic [47:0] mac;
	logic [7:0] good_cnt;
	logic [7:0] bad_cnt;
	logic [7:0] drop_cnt;
	logic [7:0] beat_mem [0:39];
	logic [7:0] reg_mem [0:39];
	logic [7:0] hold [0:7];

	logic det_en;
	logic beat_ser;
	logic beat_en;
	logic reg_en;
	logic reg_each;
	logic reg_mac;
	logic is_client;
	spcd_mode_type mode;

	assign det_en = ctrl[`SPCD_CTRL_DET];
	assign mode = spcd_mode_type'(ctrl[`SPCD_CTRL_MODE +: 2]);
	assign beat_ser = ctrl[`SPCD_CTRL_BEAT_SER];
	assign beat_en = ctrl[`SPCD_CTRL_BEAT_EN];
	assign reg_en = ctrl[`SPCD_CTRL_REG_EN];
	assign reg_each = ctrl[`SPCD_CTRL_REG_EACH];
	assign reg_mac = ctrl[`SPCD_CTRL_REG_MAC];
	assign is_client = (mode == MODE_STREAM_CLIENT) || (mode == MODE_DGRAM_CLIENT);

	function automatic logic [5:0] clamp_len(input logic [5:0] v);
		return (v > `SPCD_CONTENT_MAX) ? `SPCD_CONTENT_MAX : v;
	endfunction

	// APB slave, zero wait states
	logic setup;
	logic wr;
	logic hit;
	logic [31:0] rd_mux;
	assign setup = psel & ~penable;
	assign wr = psel & penable & pready & pwrite;

	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h0;
		unique case (paddr)
			`SPCD_ADDR_CTRL: rd_mux = {24'h0, ctrl};
			`SPCD_ADDR_LINE: rd_mux = line;
			`SPCD_ADDR_PACK: rd_mux = {12'h0, idle_chars, 6'h0, pack_len};
			`SPCD_ADDR_BEAT: rd_mux = {beat_period, 2'h0, reg_len, 2'h0, beat_len};
			`SPCD_ADDR_MEM: rd_mux = 32'h0;
			`SPCD_ADDR_MAC_LO: rd_mux = mac[31:0];
			`SPCD_ADDR_MAC_HI: rd_mux = {16'h0, mac[47:32]};
			`SPCD_ADDR_STAT: rd_mux = {drop_cnt, 8'h0, bad_cnt, good_cnt};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			prdata <= (setup && !pwrite && hit) ? rd_mux : 32'h0;
			pslverr <= setup & ~hit;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= `SPCD_CTRL_RST;
			pack_len <= `SPCD_PACK_LEN_RST;
			idle_chars <= `SPCD_IDLE_CHARS_RST;
			beat_len <= 6'h0;
			reg_len <= 6'h0;
			beat_period <= 16'h0;
			mac <= 48'h0;
		end else if (wr) begin
			if (paddr == `SPCD_ADDR_CTRL) ctrl <= pwdata[7:0];
			if (paddr == `SPCD_ADDR_PACK) begin
				pack_len <= pwdata[9:0];
				idle_chars <= pwdata[19:16];
			end
			if (paddr == `SPCD_ADDR_BEAT) begin
				beat_len <= clamp_len(pwdata[5:0]);
				reg_len <= clamp_len(pwdata[13:8]);
				beat_period <= pwdata[31:16];
			end
			if (paddr == `SPCD_ADDR_MAC_LO) mac[31:0] <= pwdata;
			if (paddr == `SPCD_ADDR_MAC_HI) mac[47:32] <= pwdata[15:0];
		end
	end

	// Content memories are data, left without reset
	always_ff @(posedge pclk) begin
		if (wr && paddr == `SPCD_ADDR_MEM && pwdata[`SPCD_MEM_IDX +: 6] < `SPCD_CONTENT_MAX) begin
			if (pwdata[`SPCD_MEM_SEL]) begin
				reg_mem[pwdata[`SPCD_MEM_IDX +: 6]] <= pwdata[7:0];
			end else begin
				beat_mem[pwdata[`SPCD_MEM_IDX +: 6]] <= pwdata[7:0];
			end
		end
	end

	// Live line settings, volatile; a command beats a bus write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line <= {`SPCD_FMT_RST, `SPCD_BAUD_RST};
		end else if (cmd_apply) begin
			line <= new_line;
		end else if (wr && paddr == `SPCD_ADDR_LINE) begin
			line <= pwdata;
		end
	end

	// Heartbeat timer
	logic [15:0] tick_cnt;
	logic [15:0] beat_ms;
	logic beat_fire;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 16'h0;
			beat_ms <= 16'h0;
			beat_fire <= 1'b0;
		end else begin
			beat_fire <= 1'b0;
			tick_cnt <= (tick_cnt == 16'(TICK_CYCLES - 1)) ? 16'h0 : tick_cnt + 16'h1;
			if (!beat_en || beat_period == 16'h0) begin
				beat_ms <= 16'h0;
			end else if (tick_cnt == 16'(TICK_CYCLES - 1)) begin
				if (beat_ms >= beat_period - 16'h1) begin
					beat_ms <= 16'h0;
					beat_fire <= 1'b1;
				end else begin
					beat_ms <= beat_ms + 16'h1;
				end
			end
		end
	end

	// Network to serial path with command detection
	spcd_ser_state_type pstate;
	logic [2:0] cnt;
	logic [3:0] dlen;
	logic [5:0] ptr;
	logic send_valid;
	logic [7:0] send_data;
	logic uart_ready;
	logic bit_tick;
	logic beat_ser_pend;
	logic accept;
	logic beat_go;
	logic hdr_ok;
	logic [7:0] b;
	logic [7:0] sum8;
	logic cmd_ok;

	assign accept = net_rx.valid & net_rx_ready;
	assign b = net_rx.data;
	assign beat_go = beat_ser_pend && pstate == P_IDLE && cnt == 3'h0 && !net_rx_ready && !send_valid;

	always_comb begin
		unique case (cnt)
			3'h0: hdr_ok = (b == `SPCD_HDR0);
			3'h1: hdr_ok = (b == `SPCD_HDR1);
			3'h2: hdr_ok = (b == `SPCD_HDR2);
			default: hdr_ok = 1'b1;
		endcase
		sum8 = hold[3] + hold[4] + hold[5] + hold[6];
		cmd_ok = (b == sum8) && (hold[6][`SPCD_FMT_RSVD +: 2] == 2'h0)
			&& ({hold[3], hold[4], hold[5]} >= `SPCD_MIN_BAUD);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pstate <= P_IDLE;
			cnt <= 3'h0;
			dlen <= 4'h0;
			ptr <= 6'h0;
			send_valid <= 1'b0;
			send_data <= 8'h00;
			net_rx_ready <= 1'b0;
			cmd_apply <= 1'b0;
			new_line <= {`SPCD_FMT_RST, `SPCD_BAUD_RST};
			good_cnt <= 8'h00;
			bad_cnt <= 8'h00;
			beat_ser_pend <= 1'b0;
			for (int i = 0; i < 8; i++) hold[i] <= 8'h00;
		end else begin
			cmd_apply <= 1'b0;
			if (send_valid && uart_ready) send_valid <= 1'b0;
			// Set wins over the clear
			beat_ser_pend <= (beat_ser_pend & ~beat_go) | (beat_fire & beat_ser);
			net_rx_ready <= (pstate == P_IDLE) && !send_valid && !accept && !beat_go
				&& !(beat_ser_pend && cnt == 3'h0) && !(!det_en && cnt != 3'h0);
			unique case (pstate)
				P_IDLE: begin
					if (accept) begin
						if (!det_en || (cnt == 3'h0 && !hdr_ok)) begin
							send_valid <= 1'b1;
							send_data <= b;
						end else if (!hdr_ok) begin
							hold[cnt] <= b;
							dlen <= {1'b0, cnt} + 4'h1;
							ptr <= 6'h0;
							cnt <= 3'h0;
							pstate <= P_DRAIN;
							bad_cnt <= bad_cnt + 8'h01;
						end else if (cnt == `SPCD_CMD_LAST) begin
							cnt <= 3'h0;
							if (cmd_ok) begin
								new_line <= {hold[6], hold[3], hold[4], hold[5]};
								cmd_apply <= 1'b1;
								good_cnt <= good_cnt + 8'h01;
							end else begin
								hold[7] <= b;
								dlen <= 4'h8;
								ptr <= 6'h0;
								pstate <= P_DRAIN;
								bad_cnt <= bad_cnt + 8'h01;
							end
						end else begin
							hold[cnt] <= b;
							cnt <= cnt + 3'h1;
						end
					end else if (!det_en && cnt != 3'h0) begin
						dlen <= {1'b0, cnt};
						ptr <= 6'h0;
						cnt <= 3'h0;
						pstate <= P_DRAIN;
					end else if (beat_go) begin
						ptr <= 6'h0;
						pstate <= P_BEAT;
					end
				end
				P_DRAIN: begin
					if (!send_valid) begin
						send_valid <= 1'b1;
						send_data <= hold[ptr[2:0]];
						ptr <= ptr + 6'h1;
						if ({2'h0, dlen} == ptr + 6'h1) pstate <= P_IDLE;
					end
				end
				P_BEAT: begin
					if (beat_len == 6'h0) begin
						pstate <= P_IDLE;
					end else if (!send_valid) begin
						send_valid <= 1'b1;
						send_data <= beat_mem[ptr];
						ptr <= ptr + 6'h1;
						if (beat_len == ptr + 6'h1) pstate <= P_IDLE;
					end
				end
				default: pstate <= P_IDLE;
			endcase
		end
	end

	spcd_uart_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.line(line),
		.in_valid(send_valid),
		.in_data(send_data),
		.in_ready(uart_ready),
		.txd(uart_txd),
		.bit_tick(bit_tick)
	);

	// Serial to network framing
	spcd_net_state_type nstate;
	logic [5:0] eidx;
	logic elast;
	logic pkt_open;
	logic [9:0] pkt_cnt;
	logic sbuf_valid;
	logic [7:0] sbuf_data;
	logic [7:0] gap_bits;
	logic [11:0] gap_cyc;
	logic link_q;
	logic reg_conn_pend;
	logic beat_net_pend;
	logic out_free;
	logic reg_go;
	logic nbeat_go;
	logic prefix_go;
	logic take;
	logic idle_expire;
	logic [5:0] reg_eff;
	logic [7:0] reg_byte;

	always_comb begin
		out_free = !net_tx.valid || net_tx_ready;
		idle_expire = pkt_open && !sbuf_valid && (gap_cyc >= 12'(`SPCD_MIN_IDLE_CYCLES))
			&& (gap_bits >= 8'({4'h0, idle_chars} * `SPCD_CHAR_BITS));
		reg_go = out_free && nstate == N_IDLE && reg_conn_pend && !pkt_open;
		nbeat_go = out_free && nstate == N_IDLE && !reg_go && beat_net_pend && !pkt_open;
		prefix_go = out_free && nstate == N_IDLE && !reg_go && !nbeat_go && sbuf_valid
			&& !pkt_open && reg_en && reg_each;
		take = out_free && nstate == N_IDLE && !reg_go && !nbeat_go && !prefix_go && sbuf_valid;
		reg_eff = reg_mac ? `SPCD_MAC_LEN : reg_len;
		reg_byte = reg_mac ? mac[8 * (5 - int'(eidx)) +: 8] : reg_mem[eidx];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gap_bits <= 8'h00;
			gap_cyc <= 12'h000;
		end else if (ser_rx.valid) begin
			gap_bits <= 8'h00;
			gap_cyc <= 12'h000;
		end else begin
			if (bit_tick && gap_bits != 8'hFF) gap_bits <= gap_bits + 8'h01;
			if (gap_cyc != 12'hFFF) gap_cyc <= gap_cyc + 12'h001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nstate <= N_IDLE;
			eidx <= 6'h0;
			elast <= 1'b0;
			pkt_open <= 1'b0;
			pkt_cnt <= 10'h000;
			sbuf_valid <= 1'b0;
			sbuf_data <= 8'h00;
			drop_cnt <= 8'h00;
			link_q <= 1'b0;
			reg_conn_pend <= 1'b0;
			beat_net_pend <= 1'b0;
			net_tx <= '0;
		end else begin
			link_q <= link_up;
			reg_conn_pend <= (reg_conn_pend & ~reg_go) | (link_up & ~link_q & reg_en & ~reg_each);
			beat_net_pend <= (beat_net_pend & ~nbeat_go) | (beat_fire & ~beat_ser & is_client);
			// One byte of slack only; serial cannot be stalled
			if (ser_rx.valid) begin
				sbuf_data <= ser_rx.data;
				sbuf_valid <= 1'b1;
				if (sbuf_valid && !take) drop_cnt <= drop_cnt + 8'h01;
			end else if (take) begin
				sbuf_valid <= 1'b0;
			end
			if (net_tx.valid && net_tx_ready) net_tx.valid <= 1'b0;
			if (out_free) begin
				unique case (nstate)
					N_IDLE: begin
						if (reg_go || prefix_go) begin
							nstate <= N_REG;
							eidx <= 6'h0;
							elast <= reg_go;
							if (prefix_go) pkt_open <= 1'b1;
						end else if (nbeat_go) begin
							nstate <= N_BEAT;
							eidx <= 6'h0;
							elast <= 1'b1;
						end else if (take) begin
							net_tx <= {1'b1, sbuf_data, (pkt_cnt + 10'h001 == pack_len), 1'b0};
							if (pkt_cnt + 10'h001 == pack_len) begin
								pkt_open <= 1'b0;
								pkt_cnt <= 10'h000;
							end else begin
								pkt_open <= 1'b1;
								pkt_cnt <= pkt_cnt + 10'h001;
							end
						end else if (idle_expire) begin
							net_tx <= {1'b1, 8'h00, 1'b1, 1'b1};
							pkt_open <= 1'b0;
							pkt_cnt <= 10'h000;
						end
					end
					N_REG: begin
						if (reg_eff == 6'h0) begin
							nstate <= N_IDLE;
						end else begin
							net_tx <= {1'b1, reg_byte, elast && (eidx + 6'h1 == reg_eff), 1'b0};
							eidx <= eidx + 6'h1;
							if (eidx + 6'h1 == reg_eff) nstate <= N_IDLE;
						end
					end
					N_BEAT: begin
						if (beat_len == 6'h0) begin
							nstate <= N_IDLE;
						end else begin
							net_tx <= {1'b1, beat_mem[eidx], (eidx + 6'h1 == beat_len), 1'b0};
							eidx <= eidx + 6'h1;
							if (eidx + 6'h1 == beat_len) nstate <= N_IDLE;
						end
					end
					default: nstate <= N_IDLE;
				endcase
			end
		end
	end

endmodule

// ---- sim/spcd_monitor.sv ----
// Port-level checker for the serial parameter command detector
`timescale 1ns/100ps
`include "spcd_cfg.svh"
module spcd_monitor #(
	parameter int TICK_CYCLES = `SPCD_BEAT_TICK_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input spcd_pkg::spcd_byte_type net_rx,
	input wire logic net_rx_ready,
	input spcd_pkg::spcd_byte_type ser_rx,
	input spcd_pkg::spcd_net_type net_tx,
	input wire logic net_tx_ready,
	input wire logic link_up,
	input wire logic uart_txd
);
	import spcd_pkg::*;
	logic [9:0] pack_cnt;
	logic [11:0] gap;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bytes in the open frame; any close restarts the count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pack_cnt <= 10'h000;
		else if (net_tx.valid && net_tx_ready && net_tx.last) pack_cnt <= 10'h000;
		else if (net_tx.valid && net_tx_ready && !net_tx.nodata) pack_cnt <= pack_cnt + 10'h001;
	end
	// Saturates far above the idle floor so it never wraps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) gap <= 12'h000;
		else if (ser_rx.valid) gap <= 12'h000;
		else if (gap != 12'hFFF) gap <= gap + 12'h001;
	end
	a_pready_single: assert property (
		psel && !penable |=> pready ##1 !pready) else $error("APB answer not one cycle after setup");
	a_unmapped_err: assert property (
		psel && !penable && paddr > 8'h1C |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
	a_rdata_idle: assert property (
		!pready |-> prdata == 32'h0) else $error("read data outside access cycle");
	a_rx_ready_drop: assert property (
		net_rx.valid && net_rx_ready |=> !net_rx_ready) else $error("network byte not held back after accept");
	a_tx_hold: assert property (
		net_tx.valid && !net_tx_ready |=> net_tx.valid && $stable(net_tx)) else $error("frame byte changed while stalled");
	a_marker_form: assert property (
		net_tx.valid && net_tx.nodata |-> net_tx.last && net_tx.data == 8'h00) else $error("bad close marker");
	a_pack_limit: assert property (
		net_tx.valid && !net_tx.nodata && pack_cnt == (`SPCD_PACK_LEN_RST - 10'h001) |-> net_tx.last)
		else $error("frame not closed at length limit");
	a_idle_floor: assert property (
		net_tx.valid && net_tx.nodata |-> gap >= `SPCD_MIN_IDLE_CYCLES) else $error("idle close too early");
	c_pack_close: cover property (net_tx.valid && net_tx_ready && net_tx.last && !net_tx.nodata);
	c_idle_close: cover property (net_tx.valid && net_tx_ready && net_tx.nodata);
	c_unmapped: cover property (pready && pslverr);
endmodule
bind spcd_top spcd_monitor #(.TICK_CYCLES(TICK_CYCLES)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .net_rx(net_rx), .net_rx_ready(net_rx_ready), .ser_rx(ser_rx), .net_tx(net_tx),
	.net_tx_ready(net_tx_ready), .link_up(link_up), .uart_txd(uart_txd));

// ---- sim/spcd_far_model.sv ----
// Far side: stalling network sink and serial line receiver
`timescale 1ns/100ps
module spcd_far_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic [23:0] baud,
	input wire logic [7:0] fmt,
	input wire logic uart_txd,
	output logic net_tx_ready,
	output logic [7:0] rx_data,
	output logic rx_err
);
	event got;
	logic [1:0] phase;
	logic [7:0] f;
	logic par;
	real bt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) phase <= 2'h0;
		else phase <= phase + 2'h1;
	end
	// Slow sink accepts one cycle in four
	assign net_tx_ready = !slow || phase == 2'h0;
	// Settings latched per character; a change mid-character shows as an error
	always begin
		@(negedge uart_txd);
		bt = 1.0e9 / baud;
		f = fmt;
		#(bt / 2.0);
		if (uart_txd === 1'b0) begin
			rx_data = 8'h00;
			rx_err = 1'b0;
			par = 1'b0;
			for (int i = 0; i < f[1:0] + 5; i++) begin
				#(bt);
				rx_data[i] = uart_txd;
				par = par ^ uart_txd;
			end
			if (f[3]) begin
				#(bt);
				case (f[5:4])
					2'h0: rx_err = (par ^ uart_txd) !== 1'b1;
					2'h1: rx_err = (par ^ uart_txd) !== 1'b0;
					2'h2: rx_err = uart_txd !== 1'b1;
					default: rx_err = uart_txd !== 1'b0;
				endcase
			end
			for (int i = 0; i <= f[2]; i++) begin
				#(bt);
				if (uart_txd !== 1'b1) rx_err = 1'b1;
			end
			->got;
		end
	end
endmodule

// ---- sim/tb_serial_param_command_detector.sv ----
// Self-checking bench for the serial parameter command detector
`timescale 1ns/100ps
`include "spcd_cfg.svh"
module tb_serial_param_command_detector;
	import spcd_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, link_up = 1'b0, slow = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, net_rx_ready, net_tx_ready, uart_txd, rx_err;
	spcd_byte_type net_rx = '0, ser_rx = '0;
	spcd_net_type net_tx;
	logic [23:0] cur_baud = `SPCD_BAUD_RST;
	logic [7:0] cur_fmt = `SPCD_FMT_RST, b, rx_data;
	logic [47:0] mac;
	logic [32:0] exp_reg[$];
	logic [8:0] exp_ser[$];
	logic [9:0] exp_net[$];
	logic [7:0] fmts [6] = '{8'h00, 8'h2D, 8'h0F, 8'h3E, 8'h1A, 8'h03};
	int num_errors = 0, checks_done = 0, seed = 40650;
	always #25 pclk = ~pclk;
	spcd_top #(.TICK_CYCLES(20)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .net_rx(net_rx),
		.net_rx_ready(net_rx_ready), .ser_rx(ser_rx), .net_tx(net_tx), .net_tx_ready(net_tx_ready),
		.link_up(link_up), .uart_txd(uart_txd));
	spcd_far_model far (.pclk(pclk), .presetn(presetn), .slow(slow), .baud(cur_baud), .fmt(cur_fmt),
		.uart_txd(uart_txd), .net_tx_ready(net_tx_ready), .rx_data(rx_data), .rx_err(rx_err));
	task results();
		$display("errors=%0d checks=%0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task timeout();
		num_errors++;
		results();
	endtask
	task report(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task check_reg(input logic [32:0] g, input logic [32:0] e);
		report(g, e);
	endtask
	task check_ser(input logic [8:0] g, input logic [8:0] e);
		report({24'h0, g}, {24'h0, e});
	endtask
	task check_net(input logic [9:0] g, input logic [9:0] e);
		report({23'h0, g}, {23'h0, e});
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) timeout();
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [7:0] a, input logic [32:0] e);
		exp_reg.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task expect_ser(input logic [7:0] d);
		exp_ser.push_back({1'b0, d & (8'hFF >> (2'h3 - cur_fmt[1:0]))});
	endtask
	// Offers a byte only as fast as the serial side drains it
	task send_net(input logic [7:0] d);
		int n;
		n = 0;
		net_rx <= {1'b1, d};
		do begin
			@(posedge pclk);
			n++;
		end while (net_rx_ready !== 1'b1 && n < 20000);
		if (n >= 20000) timeout();
		net_rx <= {1'b0, d};
		@(posedge pclk);
	endtask
	task send_cmd(input logic [23:0] bd, input logic [7:0] f, input logic [7:0] bad, input logic ok);
		logic [7:0] c [8];
		c = '{`SPCD_HDR0, `SPCD_HDR1, `SPCD_HDR2, bd[23:16], bd[15:8], bd[7:0], f, 8'h00};
		c[7] = bd[23:16] + bd[15:8] + bd[7:0] + f + bad;
		for (int i = 0; i < 8; i++) begin
			if (!ok) expect_ser(c[i]);
			send_net(c[i]);
		end
		if (ok) begin
			cur_baud = bd;
			cur_fmt = f;
		end
	endtask
	task send_ser(input logic [7:0] d);
		ser_rx <= {1'b1, d};
		@(posedge pclk);
		ser_rx <= {1'b0, d};
		repeat (3) @(posedge pclk);
	endtask
	task drain();
		int n;
		n = 0;
		while (exp_ser.size() + exp_net.size() > 0 && n < 20000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 20000) timeout();
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			if (exp_reg.size() == 0) check_reg(33'h1FFFFFFFF, 33'h0);
			else check_reg({pslverr, prdata}, exp_reg.pop_front());
		end
		if (net_tx.valid === 1'b1 && net_tx_ready) begin
			if (exp_net.size() == 0) check_net(10'h3FF, 10'h000);
			else check_net({net_tx.nodata, net_tx.last, net_tx.data}, exp_net.pop_front());
		end
	end
	always @(far.got) begin
		if (exp_ser.size() == 0) check_ser(9'h1FF, 9'h000);
		else check_ser({rx_err, rx_data}, exp_ser.pop_front());
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(`SPCD_ADDR_CTRL, {1'b0, 32'h00000001});
		rd(`SPCD_ADDR_LINE, {1'b0, `SPCD_FMT_RST, `SPCD_BAUD_RST});
		rd(8'h20, {1'b1, 32'h0});
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `SPCD_ADDR_CTRL, {29'h0, 2'(i), 1'b1});
			send_cmd(24'h0F4240, fmts[i], 8'h00, 1'b1);
			rd(`SPCD_ADDR_LINE, {1'b0, fmts[i], 24'h0F4240});
			b = 8'($random(seed));
			if (b == 8'h55) b = 8'h5A;
			expect_ser(b);
			send_net(b);
			drain();
		end
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h00000001);
		send_cmd(24'h0F4240, 8'h03, 8'h01, 1'b0);
		send_cmd(24'h000257, 8'h03, 8'h00, 1'b0);
		send_cmd(24'h0F4240, 8'h43, 8'h00, 1'b0);
		expect_ser(8'h55);
		expect_ser(8'h13);
		send_net(8'h55);
		send_net(8'h13);
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h00000000);
		send_cmd(24'h0F4240, 8'h03, 8'h00, 1'b0);
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h00000001);
		drain();
		apb(1'b1, `SPCD_ADDR_STAT, 32'hFFFFFFFF);
		rd(`SPCD_ADDR_STAT, {1'b0, 32'h00000406});
		for (int i = 1; i <= 403; i++) begin
			b = 8'($random(seed));
			exp_net.push_back({1'b0, i == 400, b});
			send_ser(b);
		end
		exp_net.push_back({2'b11, 8'h00});
		drain();
		mac = {16'($random(seed)), 32'($random(seed))};
		apb(1'b1, `SPCD_ADDR_MAC_LO, mac[31:0]);
		apb(1'b1, `SPCD_ADDR_MAC_HI, {16'h0000, mac[47:32]});
		for (int k = 0; k < 6; k++) exp_net.push_back({1'b0, k == 5, mac[47 - 8 * k -: 8]});
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h000000A1);
		slow <= 1'b1;
		link_up <= 1'b1;
		drain();
		apb(1'b1, `SPCD_ADDR_MEM, 32'h000000C3);
		apb(1'b1, `SPCD_ADDR_BEAT, 32'h00640001);
		exp_net.push_back({2'b01, 8'hC3});
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h00000011);
		drain();
		expect_ser(8'hC3);
		apb(1'b1, `SPCD_ADDR_CTRL, 32'h00000019);
		drain();
		results();
	end
endmodule
